// ==== design/hbfm_fault_mgr.v ====
`timescale 1ns/1ps
`default_nettype none
`include "hbfm_regs.vh"

module hbfm_fault_mgr #(
    parameter NCH = 6,
    parameter [31:0] ULD_DELAY_CYCLES = `HBFM_ULD_DELAY_RESET
) (
    input wire pclk,
    input wire presetn,
    input wire pclken,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    input wire en_pin,
    input wire link_clk,
    input wire link_csn,
    input wire link_si,
    input wire [NCH-1:0] uld_cmp,
    input wire [NCH-1:0] oc_cmp,
    input wire [NCH-1:0] tw_sense,
    input wire [NCH-1:0] tsd_sense,
    input wire vs_uv,
    input wire vs_ov,
    output reg [NCH-1:0] hs_on,
    output reg [NCH-1:0] ls_on,
    output reg out_hiz
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers for analog comparator and enable inputs.

localparam SW = 4 * NCH + 3;

reg [SW-1:0] pin_a;
reg [SW-1:0] pin_b;
reg en_prev;

wire [NCH-1:0] uld_s = pin_b[NCH-1:0];
wire [NCH-1:0] oc_s = pin_b[2*NCH-1:NCH];
wire [NCH-1:0] tw_s = pin_b[3*NCH-1:2*NCH];
wire [NCH-1:0] tsd_s = pin_b[4*NCH-1:3*NCH];
wire uv_s = pin_b[4*NCH];
wire ov_s = pin_b[4*NCH+1];
wire en_s = pin_b[4*NCH+2];
wire en_fall = en_prev & ~en_s;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pin_a <= {SW{1'b0}};
        pin_b <= {SW{1'b0}};
        en_prev <= 1'b0;
    end
    else if (pclken)
    begin
        pin_a <= {en_pin, vs_ov, vs_uv, tsd_sense, tw_sense, oc_cmp, uld_cmp};
        pin_b <= pin_a;
        en_prev <= en_s;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Serial frame receiver supplies the status-reset request.

wire frame_valid;
wire frame_srr;

hbfm_frame_rx #(
    .CNT_W(8)
) u_frame_rx (
    .pclk(pclk),
    .presetn(presetn),
    .pclken(pclken),
    .link_clk(link_clk),
    .link_csn(link_csn),
    .link_si(link_si),
    .frame_valid(frame_valid),
    .frame_srr(frame_srr)
);

////////////////////////////////////////////////////////////////////////////////
// APB decode.

function [31:0] fit_word;
    input [NCH-1:0] v;
    begin
        fit_word = 32'h0000_0000;
        fit_word[NCH-1:0] = v;
    end
endfunction

wire apb_setup = psel & ~penable;
wire apb_wr = psel & penable & pwrite & pclken;
wire hit_ctrl = (paddr == `HBFM_CTRL_OFS);
wire hit_st = (paddr == `HBFM_STATUS_OFS);
wire hit_tsd = (paddr == `HBFM_TSD_OFS);
wire hit_dly = (paddr == `HBFM_ULD_DLY_OFS);
wire hit_raw = (paddr == `HBFM_RAW_OFS);
wire hit_any = hit_ctrl | hit_st | hit_tsd | hit_dly | hit_raw;

assign pready = pclken;

// Status-reset request from a valid frame or from a control write.
wire status_reset_request = (frame_valid & frame_srr) |
           (apb_wr & hit_ctrl & pwdata[`HBFM_CTRL_SRR_BIT]);
// Latched faults are cleared by request or enable-pin cycle; thermal latches only once that bridge has cooled.
wire clr_all = status_reset_request | en_fall;

////////////////////////////////////////////////////////////////////////////////
// Control state.

reg overvoltage_lockout_enable;
reg underload_shutdown_ctrl;
reg [NCH-1:0] br_en;
reg [NCH-1:0] br_cnf;
reg [31:0] uld_dly;

reg [NCH-1:0] uld_ch;
reg [NCH-1:0] oc_ch;
reg [NCH-1:0] tsd_ch;
reg [NCH-1:0] latch_off;
reg [31:0] uld_cnt;

wire lockout = uv_s | (ov_s & overvoltage_lockout_enable);
wire [NCH-1:0] drv_on = br_en & ~latch_off & {NCH{en_s}};

// Under-load evaluation is gated by the driver being on.
wire [NCH-1:0] uld_live = uld_s & drv_on & {NCH{~lockout}};
wire [NCH-1:0] uld_wait = uld_live & ~uld_ch;
wire uld_run = |uld_wait;
wire uld_expire = uld_run && (uld_cnt >= uld_dly - 32'h0000_0001);
wire [NCH-1:0] uld_set = uld_expire ? uld_wait : {NCH{1'b0}};
wire [NCH-1:0] oc_set = oc_s & drv_on;
wire [NCH-1:0] tsd_set = tsd_s;
wire [NCH-1:0] uld_off = uld_set & {NCH{underload_shutdown_ctrl}};
wire [NCH-1:0] off_set = oc_set | tsd_set | uld_off;

////////////////////////////////////////////////////////////////////////////////
// Shared under-load timer.

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        uld_cnt <= 32'h0000_0000;
    end
    else if (pclken)
    begin
        if (!uld_run || uld_expire)
        begin
            uld_cnt <= 32'h0000_0000;
        end
        else
        begin
            uld_cnt <= uld_cnt + 32'h0000_0001;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Latched fault memory; a new event in the clearing cycle wins.

wire [NCH-1:0] next_uld_ch = (uld_ch & {NCH{~clr_all}}) | uld_set;
wire [NCH-1:0] next_oc_ch = (oc_ch & {NCH{~clr_all}}) | oc_set;
// Thermal latch only clears while that bridge has cooled.
wire [NCH-1:0] tsd_clr = {NCH{clr_all}} & ~tsd_s;
wire [NCH-1:0] next_tsd_ch = (tsd_ch & ~tsd_clr) | tsd_set;
wire [NCH-1:0] off_clr = {NCH{clr_all}} & ~tsd_ch;
wire [NCH-1:0] next_latch_off = (latch_off & ~(off_clr | tsd_clr)) | off_set;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        uld_ch <= {NCH{1'b0}};
        oc_ch <= {NCH{1'b0}};
        tsd_ch <= {NCH{1'b0}};
        latch_off <= {NCH{1'b0}};
    end
    else if (pclken)
    begin
        uld_ch <= next_uld_ch;
        oc_ch <= next_oc_ch;
        tsd_ch <= next_tsd_ch;
        latch_off <= next_latch_off;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Control register; a latch-off event overrides a host write.

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        overvoltage_lockout_enable <= |(`HBFM_CTRL_RESET & (32'h0000_0001 << `HBFM_CTRL_OVERVOLTAGE_LOCKOUT_ENABLE_BIT));
        underload_shutdown_ctrl <= 1'b0;
        br_en <= {NCH{1'b0}};
        br_cnf <= {NCH{1'b0}};
        uld_dly <= ULD_DELAY_CYCLES;
    end
    else if (pclken)
    begin
        if (apb_wr && hit_ctrl)
        begin
            overvoltage_lockout_enable <= pwdata[`HBFM_CTRL_OVERVOLTAGE_LOCKOUT_ENABLE_BIT];
            underload_shutdown_ctrl <= pwdata[`HBFM_CTRL_UNDERLOAD_SHUTDOWN_CTRL_BIT];
            br_en <= pwdata[`HBFM_CTRL_EN_LSB +: NCH] & ~off_set;
            br_cnf <= pwdata[`HBFM_CTRL_CNF_LSB +: NCH] & ~off_set;
        end
        else
        begin
            br_en <= br_en & ~off_set;
            br_cnf <= br_cnf & ~off_set;
        end
        if (apb_wr && hit_dly)
        begin
            uld_dly <= (pwdata == 32'h0000_0000) ? 32'h0000_0001 : pwdata;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Status assembly.

reg [2*NCH-1:0] code;
integer k;

always @*
begin
    code = {(2*NCH){1'b0}};
    for (k = 0; k < NCH; k = k + 1)
    begin
        if (oc_ch[k])
        begin
            code[2*k +: 2] = `HBFM_CODE_OC;
        end
        else if (uld_ch[k])
        begin
            code[2*k +: 2] = `HBFM_CODE_ULD;
        end
        else
        begin
            code[2*k +: 2] = `HBFM_CODE_NONE;
        end
    end
end

reg [31:0] st_word;
reg [31:0] tsd_word;
reg [31:0] ctrl_word;

always @*
begin
    st_word = 32'h0000_0000;
    st_word[`HBFM_ST_TW_BIT] = |(tw_s & ~tsd_ch);
    st_word[`HBFM_ST_CODE_LSB +: 2*NCH] = code;
    st_word[`HBFM_ST_ULD_BIT] = |uld_ch;
    st_word[`HBFM_ST_PSF_BIT] = uv_s | ov_s;
    st_word[`HBFM_ST_OCS_BIT] = |oc_ch;
    tsd_word = fit_word(tsd_ch);
    tsd_word[`HBFM_TSD_FLAG_BIT] = |tsd_ch;
    ctrl_word = 32'h0000_0000;
    ctrl_word[`HBFM_CTRL_OVERVOLTAGE_LOCKOUT_ENABLE_BIT] = overvoltage_lockout_enable;
    ctrl_word[`HBFM_CTRL_EN_LSB +: NCH] = br_en;
    ctrl_word[`HBFM_CTRL_CNF_LSB +: NCH] = br_cnf;
    ctrl_word[`HBFM_CTRL_UNDERLOAD_SHUTDOWN_CTRL_BIT] = underload_shutdown_ctrl;
end

////////////////////////////////////////////////////////////////////////////////
// Read data is captured in the setup cycle and shown in the access cycle.

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
    end
    else if (pclken && apb_setup)
    begin
        pslverr <= ~hit_any;
        if (pwrite || !hit_any)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (hit_ctrl)
        begin
            prdata <= ctrl_word;
        end
        else if (hit_st)
        begin
            prdata <= st_word;
        end
        else if (hit_tsd)
        begin
            prdata <= tsd_word;
        end
        else if (hit_dly)
        begin
            prdata <= uld_dly;
        end
        else
        begin
            prdata <= fit_word(uld_s) | (fit_word(oc_s) << 8) |
                      (fit_word(tw_s) << 16) | (fit_word(tsd_s) << 24);
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Driver outputs. Lockout floats all outputs but keeps the stored setup,
// so the programmed state returns by itself when the supply recovers.

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        hs_on <= {NCH{1'b0}};
        ls_on <= {NCH{1'b0}};
        out_hiz <= 1'b1;
    end
    else if (pclken)
    begin
        out_hiz <= lockout;
        if (lockout)
        begin
            hs_on <= {NCH{1'b0}};
            ls_on <= {NCH{1'b0}};
        end
        else
        begin
            hs_on <= drv_on & ~off_set & br_cnf;
            ls_on <= drv_on & ~off_set & ~br_cnf;
        end
    end
end

endmodule
`default_nettype wire

// ==== design/hbfm_frame_rx.v ====
`timescale 1ns/1ps
`default_nettype none
`include "hbfm_regs.vh"

module hbfm_frame_rx #(
    parameter CNT_W = 8
) (
    input wire pclk,
    input wire presetn,
    input wire pclken,
    input wire link_clk,
    input wire link_csn,
    input wire link_si,
    output reg frame_valid,
    output reg frame_srr
);

////////////////////////////////////////////////////////////////////////////////
// Two-stage synchronisers, then a history stage used only for edge detection.

reg [2:0] sync_a;
reg [2:0] sync_b;
reg sclk_prev;
reg csn_prev;
reg [CNT_W-1:0] bit_cnt;
reg [`HBFM_FRAME_BITS-1:0] cmd;

wire sclk_s = sync_b[0];
wire csn_s = sync_b[1];
wire si_s = sync_b[2];
wire sclk_rise = sclk_s & ~sclk_prev;
wire csn_rise = csn_s & ~csn_prev;
wire cnt_ok = (bit_cnt >= `HBFM_FRAME_BITS) && (bit_cnt[2:0] == 3'b000);

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        sync_a <= 3'b111;
        sync_b <= 3'b111;
        sclk_prev <= 1'b1;
        csn_prev <= 1'b1;
    end
    else if (pclken)
    begin
        sync_a <= {link_si, link_csn, link_clk};
        sync_b <= sync_a;
        sclk_prev <= sclk_s;
        csn_prev <= csn_s;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Bit counting and frame qualification: 16 bits, then whole bytes only.

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        bit_cnt <= {CNT_W{1'b0}};
        cmd <= {`HBFM_FRAME_BITS{1'b0}};
        frame_valid <= 1'b0;
        frame_srr <= 1'b0;
    end
    else if (pclken)
    begin
        frame_valid <= 1'b0;
        if (csn_rise)
        begin
            frame_valid <= cnt_ok;
            frame_srr <= cnt_ok & cmd[`HBFM_FRAME_SRR_BIT];
            bit_cnt <= {CNT_W{1'b0}};
        end
        else if (csn_s)
        begin
            bit_cnt <= {CNT_W{1'b0}};
        end
        else if (sclk_rise)
        begin
            if (bit_cnt < `HBFM_FRAME_BITS)
            begin
                cmd <= {cmd[`HBFM_FRAME_BITS-2:0], si_s};
            end
            if (bit_cnt != {CNT_W{1'b1}})
            begin
                bit_cnt <= bit_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end
end

endmodule
`default_nettype wire

// ==== design/hbfm_regs.vh ====
`ifndef HBFM_REGS_VH
`define HBFM_REGS_VH

// Register byte offsets.
`define HBFM_CTRL_OFS 8'h00
`define HBFM_STATUS_OFS 8'h04
`define HBFM_TSD_OFS 8'h08
`define HBFM_ULD_DLY_OFS 8'h0c
`define HBFM_RAW_OFS 8'h10

// Control register fields.
`define HBFM_CTRL_OVERVOLTAGE_LOCKOUT_ENABLE_BIT 0
`define HBFM_CTRL_EN_LSB 1
`define HBFM_CTRL_CNF_LSB 7
`define HBFM_CTRL_UNDERLOAD_SHUTDOWN_CTRL_BIT 13
`define HBFM_CTRL_SRR_BIT 15
`define HBFM_CTRL_RESET 32'h0000_0001

// Status register fields.
`define HBFM_ST_TW_BIT 0
`define HBFM_ST_CODE_LSB 1
`define HBFM_ST_ULD_BIT 13
`define HBFM_ST_PSF_BIT 14
`define HBFM_ST_OCS_BIT 15
`define HBFM_TSD_FLAG_BIT 15
`define HBFM_TSD_CH_LSB 0

// Two-bit fault codes.
`define HBFM_CODE_NONE 2'b00
`define HBFM_CODE_OC 2'b01
`define HBFM_CODE_ULD 2'b10

// Under-load delay in system clock cycles.
`define HBFM_ULD_DELAY_RESET 32'h0000_2710

// Serial frame layout.
`define HBFM_FRAME_BITS 16
`define HBFM_FRAME_SRR_BIT 15

`endif

// ==== testbench/hbfm_fault_mgr_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module hbfm_fault_mgr_chk #(parameter NCH = 6) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic en_pin,
    input wire logic [NCH-1:0] tw_sense,
    input wire logic [NCH-1:0] tsd_sense,
    input wire logic vs_uv,
    input wire logic vs_ov,
    input wire logic [NCH-1:0] hs_on,
    input wire logic [NCH-1:0] ls_on,
    input wire logic out_hiz
);
    logic [2:0] up;
    wire logic rd = psel && !penable && paddr == 8'h04;
    wire logic [NCH-1:0] on = hs_on | ls_on;
    // Pin synchronisers restart at reset, so some checks wait until they have refilled.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            up <= 3'h0;
        else if (up != 3'h7)
            up <= up + 3'h1;
    end
    ////////////////////////////////////////
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    hiz_on_a: assert property (vs_uv [*4] ##0 up == 3'h7 |-> out_hiz)
        else $error("no lockout");
    hiz_off_a: assert property ((!vs_uv && !vs_ov) [*4] ##0 up == 3'h7 |-> !out_hiz)
        else $error("lockout stuck");
    hiz_drv_a: assert property (out_hiz [*3] |-> on == '0)
        else $error("driving in lockout");
    psf_set_a: assert property ((vs_uv || vs_ov) [*4] ##0 rd |=> prdata[14])
        else $error("supply flag low");
    psf_clr_a: assert property ((!vs_uv && !vs_ov) [*4] ##0 rd |=> !prdata[14])
        else $error("supply flag stuck");
    tw_clr_a: assert property ((tw_sense == '0) [*4] ##0 rd |=> !prdata[0])
        else $error("warning stuck");
    tsd_off_a: assert property (up == 3'h7 |-> (on & tsd_sense & $past(tsd_sense)
        & $past(tsd_sense, 2) & $past(tsd_sense, 3) & $past(tsd_sense, 4)) == '0)
        else $error("hot bridge driven");
    en_off_a: assert property ((!en_pin) [*4] |-> on == '0)
        else $error("driving while disabled");
    bad_addr_a: assert property (psel && !penable && paddr > 8'h10 |=> pslverr)
        else $error("no slave error");
    cover property (rd ##1 prdata[13]);
    cover property (out_hiz ##1 !out_hiz);
    cover property (on != '0 ##1 on == '0);
endmodule
`default_nettype wire

// ==== testbench/hbfm_spi_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module hbfm_spi_host (
    output logic link_clk,
    output logic link_csn,
    output logic link_si
);
    // The link clock rests low between frames; the data line sits at its pull-down level.
    initial
    begin
        link_clk = 1'b0;
        link_csn = 1'b1;
        link_si = 1'b0;
    end
    ////////////////////////////////////////
    task automatic send(input logic status_reset_request, input int n);
        int i;
        #7;
        link_csn = 1'b0;
        for (i = n - 1; i >= 0; i--)
        begin
            link_si = (i == n - 1) ? status_reset_request : 1'b0;
            #80;
            link_clk = 1'b1;
            #80;
            link_clk = 1'b0;
        end
        #80;
        link_csn = 1'b1;
        link_si = 1'b0;
        #100;
    endtask
endmodule
`default_nettype wire

// ==== testbench/test_half_bridge_fault_manager.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, g, e) \
    begin \
        n_tests++; \
        if ((g) !== (e)) \
        begin \
            n_errors++; \
            $display("MISMATCH %s exp %h got %h", nm, e, g); \
        end \
    end
module test_half_bridge_fault_manager;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic en_pin = 1'b1;
    logic vs_uv = 1'b0;
    logic vs_ov = 1'b0;
    logic hi = 1'b0;
    logic [5:0] underload_flag = 6'h0;
    logic [5:0] oc = 6'h0;
    logic [5:0] tw = 6'h0;
    logic [5:0] tsd = 6'h0;
    logic [31:0] q;
    wire logic [31:0] prdata;
    wire logic pready;
    wire logic pslverr;
    wire logic link_clk;
    wire logic link_csn;
    wire logic link_si;
    wire logic [5:0] hs_on;
    wire logic [5:0] ls_on;
    wire logic out_hiz;
    int n_errors = 0;
    int n_tests = 0;
    int ch;
    int c2;
    initial
        forever #10 pclk = ~pclk;
    hbfm_fault_mgr #(.NCH(6), .ULD_DELAY_CYCLES(32'h10)) i_hbfm_fault_mgr (
        .pclk(pclk), .presetn(presetn), .pclken(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .en_pin(en_pin), .link_clk(link_clk), .link_csn(link_csn),
        .link_si(link_si), .uld_cmp(underload_flag), .oc_cmp(oc), .tw_sense(tw), .tsd_sense(tsd),
        .vs_uv(vs_uv), .vs_ov(vs_ov), .hs_on(hs_on), .ls_on(ls_on), .out_hiz(out_hiz));
    hbfm_spi_host i_hbfm_spi_host (.link_clk(link_clk), .link_csn(link_csn), .link_si(link_si));
    ////////////////////////////////////////
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic end_of_test();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (k == 20)
        begin
            n_errors++;
            end_of_test();
        end
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic ctl(input logic [31:0] v);
        apb(1'b1, 8'h00, v);
        wt(6);
    endtask
    task automatic status_reset_request(input int n);
        i_hbfm_spi_host.send(1'b1, n);
        wt(8);
    endtask
    function automatic logic [31:0] cv(input int c, input logic h);
        return (32'h1 << (c + 1)) | ({31'h0, h} << (c + 7));
    endfunction
    ////////////////////////////////////////
    initial
    begin
        void'($urandom(32'hc7f2));
        wt(8);
        presetn <= 1'b1;
        rd(8'h00);
        `CHK("ctrl", q, 32'h1)
        rd(8'h20);
        `CHK("unmapped", {pslverr, q}, 33'h1_0000_0000)
        rd(8'h0c);
        `CHK("delay", q, 32'h10)
        repeat (2)
        begin
            ch = $urandom % 6;
            c2 = (ch + 1) % 6;
            hi = 1'($urandom);
            ctl(cv(ch, hi) | cv(c2, 1'b1) | 32'h1);
            tw <= 6'h1 << ($urandom % 6);
            wt(6);
            rd(8'h04);
            `CHK("tw set", {q[0], hs_on[ch], ls_on[ch]}, {1'b1, hi, !hi})
            rd(8'h10);
            `CHK("raw tw", q[21:16], tw)
            tw <= 6'h0;
            underload_flag <= (6'h1 << ch) | (6'h1 << ((ch + 2) % 6));
            wt(8);
            rd(8'h04);
            `CHK("uld early", {q[13], q[2*ch+1 +: 2]}, 3'b000)
            underload_flag <= underload_flag | (6'h1 << c2);
            wt(11);
            rd(8'h04);
            `CHK("tw clr", q[0], 1'b0)
            `CHK("uld", {q[13], q[2*ch+1 +: 2]}, 3'b110)
            `CHK("uld late", q[2*c2+1 +: 2], 2'b10)
            `CHK("uld off ch", q[2*((ch+2)%6)+1 +: 2], 2'b00)
            `CHK("uld stay", hs_on[ch] | ls_on[ch], 1'b1)
            underload_flag <= 6'h0;
            wt(6);
            rd(8'h04);
            `CHK("uld held", q[13], 1'b1)
            status_reset_request(16);
            rd(8'h04);
            `CHK("uld clr", q[13], 1'b0)
            $display("underload test done");
            ctl(cv(ch, hi) | 32'h2001);
            underload_flag <= 6'h1 << ch;
            wt(24);
            underload_flag <= 6'h0;
            rd(8'h00);
            `CHK("cfg clr", {q, hs_on[ch], ls_on[ch]}, {32'h2001, 2'b00})
            status_reset_request(16);
            ctl(cv(ch, hi) | 32'h1);
            `CHK("re-on", {hs_on[ch], ls_on[ch]}, {hi, !hi})
            underload_flag <= 6'h1 << ch;
            wt(24);
            oc <= 6'h1 << ch;
            wt(6);
            rd(8'h04);
            `CHK("oc", {q[15], q[2*ch+1 +: 2]}, 3'b101)
            oc <= 6'h0;
            underload_flag <= 6'h0;
            status_reset_request(12);
            rd(8'h04);
            `CHK("short frame", q[15], 1'b1)
            en_pin <= 1'b0;
            wt(6);
            en_pin <= 1'b1;
            wt(6);
            rd(8'h04);
            `CHK("en cycle", {q[15], q[13]}, 2'b00)
            $display("overcurrent test done");
            ctl(cv(ch, hi) | 32'h1);
            tsd <= 6'h1 << ch;
            wt(6);
            status_reset_request(24);
            rd(8'h08);
            `CHK("tsd hot", {q[15], q[ch], hs_on[ch] | ls_on[ch]}, 3'b110)
            tsd <= 6'h0;
            wt(6);
            status_reset_request(24);
            rd(8'h08);
            `CHK("tsd cool", q[15], 1'b0)
            $display("thermal test done");
            ctl(cv(ch, hi) | 32'h1);
            vs_uv <= 1'b1;
            wt(6);
            rd(8'h04);
            `CHK("uv", {q[14], out_hiz}, 2'b11)
            rd(8'h00);
            `CHK("cfg kept", q, cv(ch, hi) | 32'h1)
            vs_uv <= 1'b0;
            wt(6);
            `CHK("resume", {out_hiz, hs_on[ch], ls_on[ch]}, {1'b0, hi, !hi})
            ctl(cv(ch, hi));
            vs_ov <= 1'b1;
            wt(6);
            rd(8'h04);
            `CHK("ov", {q[14], out_hiz, hs_on[ch] | ls_on[ch]}, 3'b101)
            vs_ov <= 1'b0;
            wt(6);
            rd(8'h04);
            `CHK("ov clr", q[14], 1'b0)
            $display("supply test done");
        end
        end_of_test();
    end
endmodule
bind hbfm_fault_mgr hbfm_fault_mgr_chk #(.NCH(NCH)) i_hbfm_fault_mgr_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pslverr(pslverr), .en_pin(en_pin), .tw_sense(tw_sense),
    .tsd_sense(tsd_sense), .vs_uv(vs_uv), .vs_ov(vs_ov), .hs_on(hs_on), .ls_on(ls_on),
    .out_hiz(out_hiz));
`default_nettype wire
